// ---- sbr_pkg.sv ----
// shared types and constants for the status byte service request block
package sbr_pkg;

   // ----------------------------------------------------------------
   // status byte layout
   // ----------------------------------------------------------------
   localparam int BIT_EAV = 2;
   localparam int BIT_QSB = 3;
   localparam int BIT_MAV = 4;
   localparam int BIT_ESB = 5;
   localparam int BIT_RQS = 6;
   localparam int BIT_SPARE = 7;
   localparam int BIT_OPC = 0;
   // summary bits that may take part in a request: 3, 4, 5 and 7
   localparam logic [7:0] SUMMARY_SEL = 8'h00B8;

   // ----------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------
   localparam logic [7:0] SRE_RESET = 8'h0000;
   localparam logic [7:0] ESE_RESET = 8'h0000;
   localparam logic [7:0] SER_RESET = 8'h0000;
   localparam logic PSC_RESET = 1'b1;

   // ----------------------------------------------------------------
   // sizes and counts
   // ----------------------------------------------------------------
   localparam int BUF_AW = 4;
   localparam logic [BUF_AW:0] BUF_DEPTH = 5'h0010;
   localparam logic [1:0] RESTORE_WAIT = 2'h0003;

   // ----------------------------------------------------------------
   // command port
   // ----------------------------------------------------------------
   typedef enum logic [3:0] {
      CMD_NONE, CMD_SRE_WRITE, CMD_SRE_QUERY, CMD_STB_QUERY, CMD_ESE_WRITE,
      CMD_ESE_QUERY, CMD_ESR_QUERY, CMD_OPC, CMD_CLS, CMD_PRESET, CMD_PSC, CMD_DCL
   } sbr_cmd_code_type;

   typedef struct packed {
      logic valid;
      sbr_cmd_code_type code;
      logic [7:0] param;
   } sbr_cmd_type;

   typedef struct packed {
      logic valid;
      logic [7:0] data;
   } sbr_byte_type;

endpackage

// ---- sbr_sync.sv ----
// three-stage synchroniser with agreement filter for slow external levels
module sbr_sync
   import sbr_pkg::*;
#(
   parameter int WIDTH = 1
) (
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] stage1;
   logic [WIDTH-1:0] stage2;
   logic [WIDTH-1:0] stage3;
   wire logic [WIDTH-1:0] agree = ~(stage2 ^ stage3);
   wire logic [WIDTH-1:0] next_sync_out = (agree & stage3) | (~agree & sync_out);

   // stage1 feeds stage2 only; the filter looks at stages two and three
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         stage1 <= '0;
         stage2 <= '0;
         stage3 <= '0;
         sync_out <= '0;
      end else begin
         stage1 <= async_in;
         stage2 <= stage1;
         stage3 <= stage2;
         sync_out <= next_sync_out;
      end
   end

endmodule

// ---- sbr_resp_mem.sv ----
// byte store for the response output buffer, registered read port
module sbr_resp_mem
   import sbr_pkg::*;
(
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic wr_en,
   input wire logic [BUF_AW-1:0] wr_addr,
   input wire logic [7:0] wr_data,
   input wire logic rd_en,
   input wire logic [BUF_AW-1:0] rd_addr,
   output logic [7:0] rd_data
);

   logic [7:0] mem [0:(1<<BUF_AW)-1];

   // array has no reset: contents are only read after being written
   always_ff @(posedge ref_clk) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         rd_data <= 8'h0000;
      end else if (rd_en) begin
         rd_data <= mem[rd_addr];
      end
   end

endmodule

// ---- sbr_status_srq.sv ----
// status byte, service request enable mask, request latch and response buffer
module sbr_status_srq
   import sbr_pkg::*;
(
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire sbr_cmd_type cmd,
   output logic cmd_ready,
   input wire logic ops_busy,
   input wire logic questionable_summary_bit,
   input wire logic ques_event_pulse,
   input wire logic ques_query,
   input wire logic error_available,
   input wire logic [7:0] std_event_set,
   input wire logic serial_poll,
   input wire logic resp_pop,
   output sbr_byte_type resp_out,
   output sbr_byte_type spoll_out,
   output logic srq,
   output logic [7:0] status_summary_byte,
   output logic [7:0] service_request_mask,
   output logic power_on_clear_option,
   input wire logic [7:0] nv_mask,
   input wire logic nv_power_on_clear
);

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {ST_IDLE, ST_WAIT_STB, ST_WAIT_OPC} sbr_state_type;

   sbr_state_type state;
   sbr_state_type next_state;
   logic [7:0] ese;
   logic [7:0] ser;
   logic [7:0] prev_enabled;
   logic [7:0] cause;
   logic [1:0] restore_cnt;
   logic restored;
   logic restore_arm;
   logic [BUF_AW-1:0] wr_ptr;
   logic [BUF_AW-1:0] rd_ptr;
   logic [BUF_AW:0] count;
   logic resp_valid;
   logic [7:0] resp_data;
   logic [7:0] nv_mask_sync;
   logic nv_psc_sync;

   // ----------------------------------------------------------------
   // external nonvolatile values cross in through the filter
   // ----------------------------------------------------------------
   sbr_sync #(.WIDTH(9)) u_nv_sync (
      .ref_clk(ref_clk),
      .reset_n(reset_n),
      .async_in({nv_power_on_clear, nv_mask}),
      .sync_out({nv_psc_sync, nv_mask_sync})
   );

   // ----------------------------------------------------------------
   // command decode
   // ----------------------------------------------------------------
   wire logic cmd_take = cmd.valid && cmd_ready;
   wire logic take_sre_wr = cmd_take && (cmd.code == CMD_SRE_WRITE);
   wire logic take_sre_rd = cmd_take && (cmd.code == CMD_SRE_QUERY);
   wire logic take_stb = cmd_take && (cmd.code == CMD_STB_QUERY);
   wire logic take_ese_wr = cmd_take && (cmd.code == CMD_ESE_WRITE);
   wire logic take_ese_rd = cmd_take && (cmd.code == CMD_ESE_QUERY);
   wire logic take_esr_rd = cmd_take && (cmd.code == CMD_ESR_QUERY);
   wire logic take_opc = cmd_take && (cmd.code == CMD_OPC);
   wire logic take_cls = cmd_take && (cmd.code == CMD_CLS);
   wire logic take_psc = cmd_take && (cmd.code == CMD_PSC);
   wire logic take_dcl = cmd_take && (cmd.code == CMD_DCL);
   // the nv filter output settles one edge after its third stage fills, so load a cycle later
   wire logic restore_due = !restored && (restore_cnt == RESTORE_WAIT);
   wire logic restore_fire = !restored && restore_arm;

   // ----------------------------------------------------------------
   // in-order completion of the status query and completion command
   // ----------------------------------------------------------------
   wire logic stb_done = (state == ST_WAIT_STB) && !ops_busy;
   wire logic opc_done = (state == ST_WAIT_OPC) && !ops_busy;

   always_comb begin
      next_state = state;
      unique case (state)
         ST_IDLE: begin
            if (take_stb) begin
               next_state = ST_WAIT_STB;
            end else if (take_opc) begin
               next_state = ST_WAIT_OPC;
            end
         end
         ST_WAIT_STB: begin
            if (stb_done) begin
               next_state = ST_IDLE;
            end
         end
         ST_WAIT_OPC: begin
            if (opc_done) begin
               next_state = ST_IDLE;
            end
         end
      endcase
   end

   // ----------------------------------------------------------------
   // standard event register and its summary
   // ----------------------------------------------------------------
   // the completion bit belongs to the completion command alone
   wire logic [7:0] ext_set = std_event_set & 8'h00FE;
   wire logic [7:0] opc_set = {7'h0000, opc_done};
   wire logic ser_clear = take_cls || take_esr_rd;
   // set wins over clear so an event in the clearing cycle survives
   wire logic [7:0] next_ser = (ser_clear ? SER_RESET : ser) | ext_set | opc_set;
   wire logic esb = |(ser & ese);

   // ----------------------------------------------------------------
   // status byte, request and master summary
   // ----------------------------------------------------------------
   wire logic mav = (count != '0);
   wire logic [7:0] summary = {1'b0, 1'b0, esb, mav, questionable_summary_bit,
                               error_available, 2'b00};
   wire logic [7:0] enabled = summary & service_request_mask & SUMMARY_SEL;
   wire logic mss = |enabled;
   wire logic [7:0] rise = enabled & ~prev_enabled;
   // a fresh event pulse re-arms even while its summary stays high
   wire logic [7:0] retrig = {2'b00,
                              (|(ext_set & ese)) && service_request_mask[BIT_ESB],
                              1'b0,
                              ques_event_pulse && service_request_mask[BIT_QSB],
                              3'b000};
   wire logic [7:0] trig_bits = rise | retrig;
   wire logic trigger = |trig_bits;
   wire logic withdraw = serial_poll || (take_esr_rd && cause[BIT_ESB])
                         || (ques_query && cause[BIT_QSB]);
   // a new trigger in the poll cycle wins and raises a fresh request
   wire logic next_srq = trigger || (srq && !withdraw);
   wire logic [7:0] next_cause = trig_bits | (withdraw ? 8'h0000 : cause);
   wire logic [7:0] stb_value = {summary[7], mss, summary[5:0]};
   wire logic [7:0] poll_value = {summary[7], srq, summary[5:0]};

   // ----------------------------------------------------------------
   // enable masks and power-on option
   // ----------------------------------------------------------------
   // clear-status and preset have no path into the enable mask
   wire logic [7:0] restore_mask = nv_psc_sync ? SRE_RESET : nv_mask_sync;
   wire logic [7:0] next_sre = take_sre_wr ? cmd.param :
                               restore_fire ? restore_mask :
                               service_request_mask;
   wire logic [7:0] next_ese = take_ese_wr ? cmd.param : ese;
   wire logic next_psc = take_psc ? cmd.param[0] :
                         restore_fire ? nv_psc_sync : power_on_clear_option;

   // ----------------------------------------------------------------
   // output buffer
   // ----------------------------------------------------------------
   wire logic push_req = take_sre_rd || take_ese_rd || take_esr_rd || stb_done;
   wire logic [7:0] push_data = take_sre_rd ? service_request_mask :
                                take_ese_rd ? ese :
                                take_esr_rd ? ser :
                                stb_value;
   // a full buffer drops the response; the reader must keep up
   wire logic push = push_req && (count != BUF_DEPTH) && !take_dcl;
   wire logic pop = resp_pop && mav && !take_dcl;
   wire logic [BUF_AW:0] next_count = take_dcl ? '0 :
                                      count + {{BUF_AW{1'b0}}, push}
                                      - {{BUF_AW{1'b0}}, pop};
   wire logic next_cmd_ready = (next_state == ST_IDLE) && (restored || restore_fire);

   sbr_resp_mem u_resp_mem (
      .ref_clk(ref_clk),
      .reset_n(reset_n),
      .wr_en(push),
      .wr_addr(wr_ptr),
      .wr_data(push_data),
      .rd_en(pop),
      .rd_addr(rd_ptr),
      .rd_data(resp_data)
   );

   assign resp_out = '{valid: resp_valid, data: resp_data};

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         state <= ST_IDLE;
         cmd_ready <= 1'b0;
         restore_cnt <= '0;
         restored <= 1'b0;
         restore_arm <= 1'b0;
         service_request_mask <= SRE_RESET;
         power_on_clear_option <= PSC_RESET;
         ese <= ESE_RESET;
         ser <= SER_RESET;
      end else begin
         state <= next_state;
         cmd_ready <= next_cmd_ready;
         restore_cnt <= restored ? restore_cnt : restore_cnt + 2'h0001;
         restored <= restored || restore_fire;
         restore_arm <= restore_due;
         service_request_mask <= next_sre;
         power_on_clear_option <= next_psc;
         ese <= next_ese;
         ser <= next_ser;
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         prev_enabled <= 8'h0000;
         cause <= 8'h0000;
         srq <= 1'b0;
         status_summary_byte <= 8'h0000;
         spoll_out <= '0;
      end else begin
         prev_enabled <= enabled;
         cause <= next_cause;
         srq <= next_srq;
         status_summary_byte <= stb_value;
         spoll_out <= '{valid: serial_poll, data: poll_value};
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
         resp_valid <= 1'b0;
      end else begin
         wr_ptr <= wr_ptr + BUF_AW'(push);
         rd_ptr <= take_dcl ? (wr_ptr + BUF_AW'(push)) : rd_ptr + BUF_AW'(pop);
         count <= next_count;
         resp_valid <= pop;
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!reset_n);

   sequence s_poll_quiet;
      serial_poll && !trigger;
   endsequence

   sequence s_stb_blocked;
      (state == ST_WAIT_STB) && ops_busy;
   endsequence

   chk_mask_load: assert property (take_sre_wr |=> service_request_mask == $past(cmd.param))
      else $error("enable mask did not take the written byte");

   chk_mask_kept: assert property ((take_cls || cmd_take && cmd.code == CMD_PRESET)
      && restored |=> $stable(service_request_mask))
      else $error("clear or preset altered the enable mask");

   chk_power_on: assert property (restore_fire && nv_psc_sync |=> service_request_mask == 8'h0000)
      else $error("enable mask not cleared at power-on");

   chk_rise_request: assert property (trigger |=> srq ##0 spoll_out.valid == $past(serial_poll))
      else $error("rising enabled summary did not raise a request");

   chk_poll_clear: assert property (s_poll_quiet ##0 srq |=> !srq ##0 spoll_out.data[BIT_RQS])
      else $error("serial poll did not clear the request");

   chk_mss_hold: assert property (mss [*2] |-> status_summary_byte[BIT_RQS])
      else $error("master summary dropped while a summary bit is enabled");

   chk_stb_order: assert property (s_stb_blocked |-> !push ##1 (state == ST_WAIT_STB || !ops_busy))
      else $error("status query answered before earlier work finished");

   chk_stb_keeps: assert property (take_stb && srq && !withdraw |=> srq)
      else $error("status query cleared the request");

   chk_opc_late: assert property ($rose(ser[BIT_OPC]) |-> $past(state) == ST_WAIT_OPC && !$past(ops_busy))
      else $error("completion bit set while work pending");

   chk_dcl_empty: assert property (take_dcl |=> count == '0 ##1 !resp_valid)
      else $error("device clear left data in the buffer");

   chk_opc_summary: assert property (ese[BIT_OPC] && ser[BIT_OPC] |-> ##1 status_summary_byte[BIT_ESB]
      || $past(ser_clear))
      else $error("enabled completion event missing from event summary");

   sequence s_event_read;
      take_esr_rd && cause[BIT_ESB] && !trigger;
   endsequence

   chk_summary_or: assert property ((|(summary[5:3] & service_request_mask[5:3]))
      |=> status_summary_byte[BIT_RQS])
      else $error("enabled summary bit missing from bit 6");

   chk_summary_quiet: assert property (!(|(summary[5:3] & service_request_mask[5:3]))
      && !(summary[BIT_SPARE] && service_request_mask[BIT_SPARE]) |=> !status_summary_byte[BIT_RQS])
      else $error("bit 6 set with no enabled summary bit");

   chk_mav_set: assert property (count != '0 |=> status_summary_byte[BIT_MAV])
      else $error("message available missing while buffer holds data");

   chk_mav_clear: assert property (count == '0 |=> !status_summary_byte[BIT_MAV])
      else $error("message available set with empty buffer");

   chk_summary_live: assert property ($changed(questionable_summary_bit)
      |=> status_summary_byte[BIT_QSB] == $past(questionable_summary_bit))
      else $error("summary bit did not follow its source");

   chk_mask_query: assert property (take_sre_rd && count != BUF_DEPTH
      |-> push && push_data == service_request_mask)
      else $error("mask query did not return the enable mask");

   chk_event_withdraw: assert property (s_event_read |=> !srq)
      else $error("event register read did not withdraw the request");

   chk_rearm_event: assert property (ques_event_pulse && service_request_mask[BIT_QSB] |=> srq)
      else $error("fresh enabled event did not request service again");

   chk_query_mss: assert property (stb_done
      |-> push_data[BIT_RQS] == (|(summary[5:3] & service_request_mask[5:3])))
      else $error("status query bit 6 is not the master summary");

   chk_poll_flag: assert property (spoll_out.valid |-> spoll_out.data[BIT_RQS] == $past(srq))
      else $error("poll byte bit 6 is not the request flag");

endmodule

// ---- sbr_ctrl_model.sv ----
// bus controller model: serial polls on request or after the request line stands a while
module sbr_ctrl_model
   import sbr_pkg::*;
(
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic poll_req,
   input wire logic auto_en,
   input wire logic [3:0] auto_wait,
   input wire logic srq,
   input wire sbr_byte_type spoll_out,
   output logic serial_poll,
   output logic [7:0] poll_byte,
   output logic [7:0] poll_count
);
   timeunit 1ns;
   timeprecision 100ps;
   // ----------------------------------------------------------------
   // poll issue
   // ----------------------------------------------------------------
   logic [3:0] srq_age;
   logic pending;
   logic fire;
   // one poll at a time: a second poll before the byte returns would be lost
   assign fire = !pending && (poll_req || (auto_en && srq && srq_age == auto_wait));
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         serial_poll <= 1'b0;
         pending <= 1'b0;
         srq_age <= 4'h0;
         poll_byte <= 8'h00;
         poll_count <= 8'h00;
      end else begin
         serial_poll <= fire;
         pending <= fire || (pending && !spoll_out.valid);
         srq_age <= (srq && !pending) ? srq_age + 4'h1 : 4'h0;
         if (spoll_out.valid) begin
            poll_byte <= spoll_out.data;
            poll_count <= poll_count + 8'h01;
         end
      end
   end
endmodule

// ---- tb_sbr_status_srq.sv ----
// self-checking bench for the status byte service request block
module tb_sbr_status_srq
   import sbr_pkg::*;
();
   timeunit 1ns;
   timeprecision 100ps;
   // ----------------------------------------------------------------
   // signals
   // ----------------------------------------------------------------
   logic ref_clk = 1'b0;
   logic reset_n = 1'b0;
   sbr_cmd_type cmd = '0;
   logic cmd_ready, srq, power_on_clear_option, serial_poll;
   logic ops_busy = 1'b0, questionable_summary_bit = 1'b0, ques_event_pulse = 1'b0;
   logic ques_query = 1'b0, error_available = 1'b0, resp_pop = 1'b0;
   logic poll_req = 1'b0, auto_en = 1'b0, nv_power_on_clear = 1'b1;
   logic [7:0] std_event_set = 8'h00, nv_mask = 8'h5A;
   logic [7:0] status_summary_byte, service_request_mask, poll_byte, poll_count;
   sbr_byte_type resp_out, spoll_out;
   int fail_count = 0;
   int checks_done = 0;
   typedef struct packed {logic [7:0] mask; logic q; logic mss;} sbr_row_type;
   sbr_row_type rows [6] = '{'{8'h00, 1'b1, 1'b0}, '{8'h08, 1'b1, 1'b1}, '{8'h08, 1'b0, 1'b0},
      '{8'hF7, 1'b1, 1'b0}, '{8'hFF, 1'b0, 1'b0}, '{8'hFF, 1'b1, 1'b1}};

   sbr_status_srq sbr_status_srq_i (.ref_clk(ref_clk), .reset_n(reset_n), .cmd(cmd),
      .cmd_ready(cmd_ready), .ops_busy(ops_busy),
      .questionable_summary_bit(questionable_summary_bit), .ques_event_pulse(ques_event_pulse),
      .ques_query(ques_query), .error_available(error_available), .std_event_set(std_event_set),
      .serial_poll(serial_poll), .resp_pop(resp_pop), .resp_out(resp_out), .spoll_out(spoll_out),
      .srq(srq), .status_summary_byte(status_summary_byte),
      .service_request_mask(service_request_mask), .power_on_clear_option(power_on_clear_option),
      .nv_mask(nv_mask), .nv_power_on_clear(nv_power_on_clear));
   sbr_ctrl_model sbr_ctrl_model_i (.ref_clk(ref_clk), .reset_n(reset_n), .poll_req(poll_req),
      .auto_en(auto_en), .auto_wait(4'h6), .srq(srq), .spoll_out(spoll_out),
      .serial_poll(serial_poll), .poll_byte(poll_byte), .poll_count(poll_count));

   initial begin
      forever #2.5 ref_clk = ~ref_clk;
   end
   // ----------------------------------------------------------------
   // tasks
   // ----------------------------------------------------------------
   task automatic chk_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
      checks_done++;
      if (got !== exp) begin
         fail_count++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic chk_bit(input string what, input logic exp, input logic got);
      checks_done++;
      if (got !== exp) begin
         fail_count++;
         $display("wrong value %s expected %b seen %b", what, exp, got);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(negedge ref_clk);
   endtask
   // bounded wait so a stuck ready flag cannot hang the run
   task automatic wait_ready;
      int n;
      n = 0;
      while (cmd_ready !== 1'b1 && n < 60) begin
         @(negedge ref_clk);
         n++;
      end
      chk_bit("cmd_ready", 1'b1, cmd_ready);
   endtask
   task automatic send(input sbr_cmd_code_type code, input logic [7:0] param);
      @(posedge ref_clk);
      cmd <= '{1'b1, code, param};
      @(negedge ref_clk);
      wait_ready();
      @(posedge ref_clk);
      cmd <= '0;
   endtask
   task automatic pop(input string what, input logic [7:0] exp);
      @(posedge ref_clk);
      resp_pop <= 1'b1;
      @(posedge ref_clk);
      resp_pop <= 1'b0;
      @(negedge ref_clk);
      chk_bit("response valid", 1'b1, resp_out.valid);
      chk_byte(what, exp, resp_out.data);
   endtask
   task automatic poll(input logic [7:0] exp);
      logic [7:0] c;
      c = poll_count;
      @(posedge ref_clk);
      poll_req <= 1'b1;
      @(posedge ref_clk);
      poll_req <= 1'b0;
      tick(3);
      chk_byte("poll count", c + 8'h01, poll_count);
      chk_byte("poll byte", exp, poll_byte);
   endtask
   task automatic pulse_ques(input logic query);
      @(posedge ref_clk);
      ques_event_pulse <= !query;
      ques_query <= query;
      @(posedge ref_clk);
      ques_event_pulse <= 1'b0;
      ques_query <= 1'b0;
      tick(3);
   endtask
   task automatic do_reset(input logic nvc, input logic [7:0] nvm, input logic [7:0] exp);
      @(posedge ref_clk);
      reset_n <= 1'b0;
      nv_power_on_clear <= nvc;
      nv_mask <= nvm;
      tick(5);
      chk_bit("clear option in reset", 1'b1, power_on_clear_option);
      chk_bit("srq in reset", 1'b0, srq);
      @(posedge ref_clk);
      reset_n <= 1'b1;
      tick(2);
      wait_ready();
      tick(1);
      chk_byte("mask after power-on", exp, service_request_mask);
   endtask
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   // ----------------------------------------------------------------
   // tests
   // ----------------------------------------------------------------
   initial begin
      do_reset(1'b1, 8'h5A, 8'h00);
      $display("test power-on clear done");
      foreach (rows[i]) begin
         @(posedge ref_clk);
         questionable_summary_bit <= rows[i].q;
         send(CMD_SRE_WRITE, rows[i].mask);
         tick(3);
         chk_byte("mask", rows[i].mask, service_request_mask);
         chk_bit("summary bit", rows[i].q, status_summary_byte[BIT_QSB]);
         chk_bit("master summary", rows[i].mss, status_summary_byte[BIT_RQS]);
         send(CMD_SRE_QUERY, 8'h00);
         pop("mask query", rows[i].mask);
         tick(3);
      end
      $display("test mask rows done");
      send(CMD_SRE_WRITE, 8'h08);
      tick(2);
      poll(8'h48);
      chk_bit("srq after poll", 1'b0, srq);
      chk_byte("status after poll", 8'h48, status_summary_byte);
      pulse_ques(1'b0);
      chk_bit("srq re-armed", 1'b1, srq);
      @(posedge ref_clk);
      ops_busy <= 1'b1;
      error_available <= 1'b1;
      send(CMD_STB_QUERY, 8'h00);
      tick(4);
      chk_bit("ready while busy", 1'b0, cmd_ready);
      chk_bit("no early answer", 1'b0, status_summary_byte[BIT_MAV]);
      @(posedge ref_clk);
      ops_busy <= 1'b0;
      wait_ready();
      pop("status query", 8'h4C);
      chk_bit("srq kept by query", 1'b1, srq);
      pulse_ques(1'b1);
      chk_bit("srq after event read", 1'b0, srq);
      @(posedge ref_clk);
      questionable_summary_bit <= 1'b0;
      tick(3);
      chk_byte("status summaries gone", 8'h04, status_summary_byte);
      @(posedge ref_clk);
      questionable_summary_bit <= 1'b1;
      error_available <= 1'b0;
      tick(3);
      chk_bit("srq on rising summary", 1'b1, srq);
      poll(8'h48);
      @(posedge ref_clk);
      questionable_summary_bit <= 1'b0;
      $display("test request and poll done");
      send(CMD_SRE_QUERY, 8'h00);
      send(CMD_ESE_QUERY, 8'h00);
      tick(3);
      chk_bit("message available", 1'b1, status_summary_byte[BIT_MAV]);
      send(CMD_DCL, 8'h00);
      tick(3);
      chk_bit("buffer cleared", 1'b0, status_summary_byte[BIT_MAV]);
      send(CMD_CLS, 8'h00);
      send(CMD_ESE_WRITE, 8'h01);
      send(CMD_SRE_WRITE, 8'h20);
      @(posedge ref_clk);
      ops_busy <= 1'b1;
      auto_en <= 1'b1;
      send(CMD_OPC, 8'h00);
      tick(4);
      chk_bit("event summary while busy", 1'b0, status_summary_byte[BIT_ESB]);
      @(posedge ref_clk);
      ops_busy <= 1'b0;
      wait_ready();
      tick(3);
      chk_bit("event summary", 1'b1, status_summary_byte[BIT_ESB]);
      chk_bit("srq on completion", 1'b1, srq);
      tick(12);
      chk_bit("srq after slow poll", 1'b0, srq);
      chk_byte("slow poll byte", 8'h60, poll_byte);
      @(posedge ref_clk);
      auto_en <= 1'b0;
      send(CMD_ESE_QUERY, 8'h00);
      pop("event mask", 8'h01);
      send(CMD_ESE_WRITE, 8'h21);
      @(posedge ref_clk);
      std_event_set <= 8'h20;
      @(posedge ref_clk);
      std_event_set <= 8'h00;
      tick(2);
      chk_bit("srq on new event", 1'b1, srq);
      send(CMD_ESR_QUERY, 8'h00);
      pop("event register", 8'h21);
      chk_bit("srq after event register read", 1'b0, srq);
      chk_bit("event summary read", 1'b0, status_summary_byte[BIT_ESB]);
      send(CMD_CLS, 8'h00);
      send(CMD_PRESET, 8'h00);
      send(CMD_NONE, 8'h00);
      tick(2);
      chk_byte("mask kept", 8'h20, service_request_mask);
      send(CMD_PSC, 8'h00);
      tick(2);
      chk_bit("clear option", 1'b0, power_on_clear_option);
      $display("test completion and clear done");
      do_reset(1'b0, 8'hA8, 8'hA8);
      $display("test power-on retain done");
      wrap_up();
   end
   // cut a hang well past the few hundred cycles the tests need
   initial begin
      repeat (5000) @(posedge ref_clk);
      fail_count++;
      wrap_up();
   end
endmodule
